// ---- src/debug_cmd_unit.sv ----
// debug command decoder and executor for the single-wire debug port
`default_nettype none
module debug_cmd_unit
(
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   // command side, from the serial shifter
   input  wire logic                     cmd_valid,
   input  wire debug_cmd_pkg::cmd_t      cmd,
   output logic                          cmd_ready,
   output logic [15:0]                   rd_data,
   output logic                          rd_valid,
   output logic                          ack_pulse,
   output logic                          ack_enabled,
   // debug enable and cpu state
   input  wire logic                     debug_enable,
   input  wire logic                     cpu_in_debug,
   output logic                          bgnd_req,
   output logic                          cpu_resume,
   output logic                          cpu_step,
   output logic                          cpu_freeze,
   output logic                          dspace_visible,
   output logic [17:0]                   dspace_base,
   output logic [17:0]                   dspace_last,
   // cpu register port
   output logic [2:0]                    reg_sel,
   output logic                          reg_we,
   output logic [15:0]                   reg_wdata,
   input  wire logic [15:0]              reg_rdata,
   // system bus port
   input  wire logic                     bus_idle,
   output logic                          mem_valid,
   output debug_cmd_pkg::mem_req_t       mem_req,
   input  wire logic                     mem_done,
   input  wire logic [15:0]              mem_rdata
);
   import debug_cmd_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_HUNT, S_ACCESS, S_NEXT} state_t;

   state_t                st_q;
   logic [WAIT_CNT_W-1:0] wait_q;
   logic                  steal_q;
   logic                  busy_q;
   logic                  ack_en_q;
   logic                  ack_q;
   logic                  leave_ack_q;
   logic                  enter_ack_q;
   logic                  in_dbg_q;
   logic                  bgnd_q;
   logic                  resume_q;
   logic                  step_q;
   logic [15:0]           rd_data_q;
   logic                  rd_valid_q;
   logic [2:0]            reg_sel_q;
   logic                  reg_we_q;
   logic [15:0]           reg_wdata_q;
   logic                  mem_valid_q;
   mem_req_t              mem_q;

   // command decode
   wire       take       = cmd_valid && (st_q == S_IDLE);
   wire [7:0] op         = cmd.op;
   wire       is_mem_rd  = (op == OP_DSPACE_BYTE_RD) || (op == OP_DSPACE_WORD_RD)
                        || (op == OP_MEM_BYTE_RD) || (op == OP_MEM_WORD_RD);
   wire       is_mem_wr  = (op == OP_DSPACE_BYTE_WR) || (op == OP_DSPACE_WORD_WR)
                        || (op == OP_MEM_BYTE_WR) || (op == OP_MEM_WORD_WR);
   wire       is_reg_rd  = (op >= OP_GET_PC) && (op <= OP_GET_SP);
   wire       is_reg_wr  = (op >= OP_SET_PC) && (op <= OP_SET_SP);
   wire       is_next    = (op == OP_READ_NEXT) || (op == OP_WRITE_NEXT);
   wire       is_go      = (op == OP_RESUME) || (op == OP_TAG_RESUME);
   wire       is_fw      = is_reg_rd || is_reg_wr || is_next || is_go
                        || (op == OP_RESUME_UNTIL) || (op == OP_SINGLE_STEP);
   wire       fw_ok      = is_fw && in_dbg_q;
   wire       dbg_rise   = cpu_in_debug && !in_dbg_q;
   wire       dbg_fall   = !cpu_in_debug && in_dbg_q;
   wire       steal_now  = (wait_q == WAIT_CNT_W'(STEAL_WAIT_CYCLES - 1));

   // byte lane selection for the addressed byte
   wire        odd_byte  = cmd.addr[0];
   wire        word_op   = op[OP_BIT_WORD];
   wire [1:0]  cmd_be    = word_op ? BE_WORD : (odd_byte ? BE_ODD : BE_EVEN);
   wire [15:0] cmd_addr  = {cmd.addr[15:1], 1'b0};
   wire [15:0] lane_mask = (mem_q.be == BE_ODD) ? LANE_LOW
                         : (mem_q.be == BE_EVEN) ? LANE_HIGH : (LANE_HIGH | LANE_LOW);
   wire [15:0] rd_lane   = mem_rdata & lane_mask;

   // handshake outputs and cpu controls
   assign cmd_ready      = (st_q == S_IDLE);
   assign rd_data        = rd_data_q;
   assign rd_valid       = rd_valid_q;
   assign ack_pulse      = ack_q;
   assign ack_enabled    = ack_en_q;
   assign bgnd_req       = bgnd_q;
   assign cpu_resume     = resume_q;
   assign cpu_step       = step_q;
   assign cpu_freeze     = (st_q == S_ACCESS) && (steal_q || busy_q);
   assign dspace_visible = in_dbg_q;
   assign dspace_base    = DSPACE_BASE;
   assign dspace_last    = DSPACE_LAST;
   assign reg_sel        = reg_sel_q;
   assign reg_we         = reg_we_q;
   assign reg_wdata      = reg_wdata_q;
   assign mem_valid      = mem_valid_q;
   assign mem_req        = '{addr: mem_q.addr, be: mem_q.be, we: mem_q.we,
                             dbg_space: mem_q.dbg_space && mem_valid_q,
                             wdata: mem_q.wdata};

   // command sequencer
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_q        <= S_IDLE;
         wait_q      <= '0;
         steal_q     <= 1'b0;
         busy_q      <= 1'b0;
         mem_valid_q <= 1'b0;
         mem_q       <= '0;
         rd_data_q   <= '0;
         rd_valid_q  <= 1'b0;
         reg_sel_q   <= REG_PC;
         reg_we_q    <= 1'b0;
         reg_wdata_q <= '0;
         resume_q    <= 1'b0;
         step_q      <= 1'b0;
      end
      else
      begin
         rd_valid_q <= 1'b0;
         reg_we_q   <= 1'b0;
         resume_q   <= 1'b0;
         step_q     <= 1'b0;
         case (st_q)
            S_IDLE:
            begin
               wait_q  <= '0;
               steal_q <= 1'b0;
               busy_q  <= 1'b0;
               if (take && (is_mem_rd || is_mem_wr))
               begin
                  mem_q <= '{addr: cmd_addr, be: cmd_be, we: is_mem_wr,
                             dbg_space: op[OP_BIT_DSPACE], wdata: cmd.data};
                  st_q  <= S_HUNT;
               end
               else if (take && fw_ok && is_next)
               begin
                  reg_sel_q <= REG_X;
                  mem_q     <= '{addr: '0, be: BE_WORD, we: (op == OP_WRITE_NEXT),
                                 dbg_space: 1'b1, wdata: cmd.data};
                  st_q      <= S_NEXT;
               end
               else if (take && fw_ok && is_reg_rd)
               begin
                  reg_sel_q  <= op[2:0];
                  st_q       <= S_NEXT;
                  mem_q.we   <= 1'b0;
                  mem_q.be   <= '0;
               end
               else if (take && fw_ok && is_reg_wr)
               begin
                  reg_sel_q   <= op[2:0];
                  reg_we_q    <= 1'b1;
                  reg_wdata_q <= cmd.data;
               end
               else if (take && fw_ok && (is_go || op == OP_RESUME_UNTIL))
                  resume_q <= 1'b1;
               else if (take && fw_ok && (op == OP_SINGLE_STEP))
                  step_q <= 1'b1;
            end
            S_HUNT:
            begin
               // take the next free cycle, else steal one
               wait_q <= wait_q + 1'b1;
               if (bus_idle || steal_now)
               begin
                  steal_q     <= !bus_idle;
                  mem_valid_q <= 1'b1;
                  st_q        <= S_ACCESS;
               end
            end
            S_NEXT:
            begin
               if (mem_q.be == '0)
               begin
                  // plain register read: value is ready this cycle
                  rd_data_q  <= reg_rdata;
                  rd_valid_q <= 1'b1;
                  st_q       <= S_IDLE;
               end
               else
               begin
                  reg_we_q    <= 1'b1;
                  reg_wdata_q <= reg_rdata + X_STEP;
                  mem_q.addr  <= reg_rdata + X_STEP;
                  mem_valid_q <= 1'b1;
                  st_q        <= S_ACCESS;
               end
            end
            S_ACCESS:
            begin
               busy_q <= !mem_done;
               if (mem_done)
               begin
                  mem_valid_q <= 1'b0;
                  rd_data_q   <= mem_q.we ? rd_data_q : rd_lane;
                  rd_valid_q  <= !mem_q.we;
                  st_q        <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // debug entry request, handshake mode and pending acknowledges
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ack_en_q    <= 1'b0;
         ack_q       <= 1'b0;
         bgnd_q      <= 1'b0;
         leave_ack_q <= 1'b0;
         enter_ack_q <= 1'b0;
         in_dbg_q    <= 1'b0;
      end
      else
      begin
         in_dbg_q <= cpu_in_debug;
         ack_q    <= 1'b0;
         if (take && op == OP_ACK_ON)
         begin
            ack_en_q <= 1'b1;
            ack_q    <= 1'b1;
         end
         else if (take && op == OP_ACK_OFF)
            ack_en_q <= 1'b0;
         else if (ack_en_q && (rd_valid_q || reg_we_q && st_q == S_IDLE
                  || st_q == S_ACCESS && mem_done && mem_q.we))
            ack_q <= 1'b1;
         else if (ack_en_q && (leave_ack_q && dbg_fall || enter_ack_q && dbg_rise))
            ack_q <= 1'b1;
         // entry request stays up until the cpu reports debug mode or debug_enable drops
         if (take && op == OP_ENTER_DEBUG && debug_enable && !in_dbg_q)
            bgnd_q <= 1'b1;
         else if (cpu_in_debug || !debug_enable)
            bgnd_q <= 1'b0;
         if (take && fw_ok && is_go)
            leave_ack_q <= 1'b1;
         else if (dbg_fall)
            leave_ack_q <= 1'b0;
         if (take && (op == OP_ENTER_DEBUG && debug_enable
                      || fw_ok && (op == OP_RESUME_UNTIL || op == OP_SINGLE_STEP)))
            enter_ack_q <= 1'b1;
         else if (dbg_rise)
            enter_ack_q <= 1'b0;
      end
   end

   // checks on the sequencer, the handshake and the entry request
   steal_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st_q == S_HUNT) |-> ##[1:129] (st_q == S_ACCESS))
      else $error("no bus cycle taken within the steal limit");
   freeze_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == S_ACCESS) && cpu_freeze && !mem_done |=> cpu_freeze)
      else $error("cpu released before access completed");
   dspace_window_a: assert property (@(posedge ref_clk) disable iff (rst)
      mem_req.dbg_space |-> mem_valid)
      else $error("debug space mapped outside an access");
   ack_gated_a: assert property (@(posedge ref_clk) disable iff (rst)
      ack_pulse |-> ack_en_q)
      else $error("ack pulse with handshake disabled");
   ack_on_a: assert property (@(posedge ref_clk) disable iff (rst)
      take && (op == OP_ACK_ON) |=> ack_pulse && ack_en_q)
      else $error("handshake enable did not ack");
   ack_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      take && (op == OP_ACK_OFF) |=> !ack_pulse && !ack_en_q)
      else $error("handshake disable misbehaved");
   enter_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
      take && (op == OP_ENTER_DEBUG) && !debug_enable && !bgnd_q |=> !bgnd_q)
      else $error("enter request raised while disabled");
   fw_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
      take && is_fw && !in_dbg_q |=> (st_q == S_IDLE) && !reg_we && !cpu_resume && !cpu_step)
      else $error("firmware command acted outside debug");
   next_step_a: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == S_NEXT) && (mem_q.be != '0) |=> reg_we && (reg_wdata == $past(reg_rdata) + X_STEP))
      else $error("index not advanced by two");
   rd_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_valid |=> !rd_valid)
      else $error("read strobe longer than one cycle");

endmodule // debug_cmd_unit
`default_nettype wire

// ---- include/debug_cmd_pkg.sv ----
// package: opcodes, field positions, timing and carrier types of the debug command unit
`default_nettype none
package debug_cmd_pkg;
   // hardware command opcodes
   localparam logic [7:0] OP_ENTER_DEBUG      = 8'h90;
   localparam logic [7:0] OP_ACK_ON           = 8'hD5;
   localparam logic [7:0] OP_ACK_OFF          = 8'hD6;
   localparam logic [7:0] OP_DSPACE_BYTE_RD   = 8'hE4;
   localparam logic [7:0] OP_DSPACE_WORD_RD   = 8'hEC;
   localparam logic [7:0] OP_MEM_BYTE_RD      = 8'hE0;
   localparam logic [7:0] OP_MEM_WORD_RD      = 8'hE8;
   localparam logic [7:0] OP_DSPACE_BYTE_WR   = 8'hC4;
   localparam logic [7:0] OP_DSPACE_WORD_WR   = 8'hCC;
   localparam logic [7:0] OP_MEM_BYTE_WR      = 8'hC0;
   localparam logic [7:0] OP_MEM_WORD_WR      = 8'hC8;
   // firmware command opcodes
   localparam logic [7:0] OP_READ_NEXT        = 8'h62;
   localparam logic [7:0] OP_GET_PC           = 8'h63;
   localparam logic [7:0] OP_GET_SP           = 8'h67;
   localparam logic [7:0] OP_WRITE_NEXT       = 8'h42;
   localparam logic [7:0] OP_SET_PC           = 8'h43;
   localparam logic [7:0] OP_SET_SP           = 8'h47;
   localparam logic [7:0] OP_RESUME           = 8'h08;
   localparam logic [7:0] OP_RESUME_UNTIL     = 8'h0C;
   localparam logic [7:0] OP_SINGLE_STEP      = 8'h10;
   localparam logic [7:0] OP_TAG_RESUME       = 8'h18;
   // opcode field positions for memory commands
   localparam int         OP_BIT_WORD         = 3;
   localparam int         OP_BIT_DSPACE       = 2;
   // cpu register select codes, equal to the low opcode bits
   localparam logic [2:0] REG_PC              = 3'h3;
   localparam logic [2:0] REG_D               = 3'h4;
   localparam logic [2:0] REG_X               = 3'h5;
   localparam logic [2:0] REG_Y               = 3'h6;
   localparam logic [2:0] REG_SP              = 3'h7;
   localparam logic [15:0] X_STEP             = 16'h0002;
   // byte lanes: even address in high byte, odd in low byte
   localparam logic [1:0] BE_EVEN             = 2'h2;
   localparam logic [1:0] BE_ODD              = 2'h1;
   localparam logic [1:0] BE_WORD             = 2'h3;
   localparam logic [15:0] LANE_LOW           = 16'h00FF;
   localparam logic [15:0] LANE_HIGH          = 16'hFF00;
   // free-cycle hunt before stealing a cycle
   localparam int         STEAL_WAIT_CYCLES   = 128;
   localparam int         WAIT_CNT_W          = 8;
   // debug space window in the global map when active
   localparam logic [17:0] DSPACE_BASE        = 18'h3_FF00;
   localparam logic [17:0] DSPACE_LAST        = 18'h3_FFFF;

   // command delivered by the serial layer
   typedef struct packed {
      logic [7:0]  op;
      logic [15:0] addr;
      logic [15:0] data;
   } cmd_t;

   // memory access request towards the system bus
   typedef struct packed {
      logic [15:0] addr;
      logic [1:0]  be;
      logic        we;
      logic        dbg_space;
      logic [15:0] wdata;
   } mem_req_t;
endpackage
`default_nettype wire

// ---- tb/bus_cpu_model.sv ----
// partner model: two-space memory, cpu register file and debug entry and exit
`default_nettype none
module bus_cpu_model
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic [1:0]              lat,
   input  wire logic                    brk,
   input  wire logic                    mem_valid,
   input  wire debug_cmd_pkg::mem_req_t mem_req,
   output logic                         mem_done,
   output logic [15:0]                  mem_rdata,
   input  wire logic [2:0]              reg_sel,
   input  wire logic                    reg_we,
   input  wire logic [15:0]             reg_wdata,
   output logic [15:0]                  reg_rdata,
   input  wire logic                    bgnd_req,
   input  wire logic                    cpu_resume,
   input  wire logic                    cpu_step,
   output logic                         cpu_in_debug
);
   timeunit 1ns;
   timeprecision 1ns;
   import debug_cmd_pkg::*;
   logic [15:0] mem [2][256] = '{default: 16'h0000};
   logic [15:0] regs [8];
   logic [1:0]  wait_q;
   logic [2:0]  dly_q;
   logic [7:0]  idx;
   logic [15:0] word;
   // word index drops the address lsb
   assign idx = mem_req.addr[8:1];
   assign word = mem[mem_req.dbg_space][idx];
   assign mem_done = mem_valid && (wait_q == lat);
   // until mem_done the bus shows the inverse of the word at the held address
   assign mem_rdata = mem_done ? word : ~word;
   assign reg_rdata = regs[reg_sel];
   // lane writes, register file, debug entry after a short delay
   always @(posedge ref_clk)
   begin
      wait_q <= (mem_valid && !mem_done) ? wait_q + 2'h1 : 2'h0;
      if (mem_done && mem_req.we && mem_req.be[1])
         mem[mem_req.dbg_space][idx][15:8] <= mem_req.wdata[15:8];
      if (mem_done && mem_req.we && mem_req.be[0])
         mem[mem_req.dbg_space][idx][7:0] <= mem_req.wdata[7:0];
      if (rst)
      begin
         cpu_in_debug <= 1'b0;
         dly_q <= 3'h0;
         foreach (regs[i]) regs[i] <= 16'h0000;
      end
      else
      begin
         if (reg_we)
            regs[reg_sel] <= reg_wdata;
         if (cpu_resume || cpu_step)
            cpu_in_debug <= 1'b0;
         if (dly_q == 3'h0 && (cpu_step || brk || (bgnd_req && !cpu_in_debug)))
            dly_q <= 3'h4;
         else if (dly_q == 3'h1)
            cpu_in_debug <= 1'b1;
         if (dly_q != 3'h0)
            dly_q <= dly_q - 3'h1;
      end
   end
endmodule // bus_cpu_model
`default_nettype wire

// ---- tb/debug_cmd_unit_tb.sv ----
// self-checking testbench of the debug command unit
`default_nettype none
module debug_cmd_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import debug_cmd_pkg::*;
   logic ref_clk = 0, rst = 1, cmd_valid = 0, debug_enable = 0, bus_idle = 1, brk = 0;
   logic [1:0] lat = 2'h0;
   cmd_t cmd = '0;
   mem_req_t mem_req;
   logic cmd_ready, rd_valid, ack_pulse, ack_enabled, cpu_in_debug, bgnd_req, cpu_resume;
   logic cpu_step, cpu_freeze, dspace_visible, reg_we, mem_valid, mem_done, mv;
   logic [15:0] rd_data, reg_wdata, reg_rdata, mem_rdata, d, a;
   logic [17:0] dspace_base, dspace_last;
   logic [2:0] reg_sel;
   int n_mismatch, checked, n_ack, n_res, n_stp, frz, t_mv, t_take, gap, k, ea;
   logic [31:0] seed = 32'h1b8f_3f5c;
   logic [15:0] rdq [$];
   logic [15:0] m [2][256] = '{default: 16'h0000};
   logic [15:0] r [8] = '{default: 16'h0000};
   debug_cmd_unit i_debug_cmd_unit (.ref_clk, .rst, .cmd_valid, .cmd, .cmd_ready, .rd_data,
      .rd_valid, .ack_pulse, .ack_enabled, .debug_enable, .cpu_in_debug, .bgnd_req,
      .cpu_resume, .cpu_step, .cpu_freeze, .dspace_visible, .dspace_base, .dspace_last,
      .reg_sel, .reg_we, .reg_wdata, .reg_rdata, .bus_idle, .mem_valid, .mem_req,
      .mem_done, .mem_rdata);
   bus_cpu_model i_bus_cpu_model (.ref_clk, .rst, .lat, .brk, .mem_valid, .mem_req,
      .mem_done, .mem_rdata, .reg_sel, .reg_we, .reg_wdata, .reg_rdata, .bgnd_req,
      .cpu_resume, .cpu_step, .cpu_in_debug);
   // clock of 100 ns
   always #50 ref_clk = ~ref_clk;
   // pulse counters, access start time and read capture
   always @(posedge ref_clk)
   begin
      if (ack_pulse === 1'b1) n_ack++;
      if (cpu_resume === 1'b1) n_res++;
      if (cpu_step === 1'b1) n_stp++;
      if (cpu_freeze === 1'b1) frz++;
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if (mem_valid === 1'b1 && !mv) t_mv = $time;
      mv = (mem_valid === 1'b1);
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one command, then the host wait, then the acknowledge count
   task automatic send(input logic [7:0] op, input logic [15:0] ad, input logic [15:0] dt,
                       input int acks);
      int c;
      c = n_ack;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd <= {op, ad, dt};
      @(posedge ref_clk);
      for (int w = 0; cmd_ready !== 1'b1 && w < 300; w++) @(posedge ref_clk);
      chk(18'(cmd_ready === 1'b1), 18'h0_0001, "command taken");
      t_take = $time;
      cmd_valid <= 1'b0;
      repeat (150) @(posedge ref_clk);
      chk(18'(n_ack - c), 18'(acks), "ack count");
   endtask
   task automatic rd(input logic [7:0] op, input logic [15:0] ad, input logic [15:0] exp,
                     input int acks);
      rdq.delete();
      send(op, ad, 16'h0000, acks);
      chk(18'(rdq.size()), 18'h0_0001, "read count");
      chk(rdq.size() == 1 ? rdq[0] : 16'hxxxx, exp, "read data");
   endtask
   // random writes then read-back in both spaces with random lanes, latency, free cycles
   task automatic mem_loop(input int n);
      logic [31:0] s;
      logic [15:0] e;
      logic [7:0]  ix;
      for (int i = 0; i < n; i++)
      begin
         s = rnd();
         a = {12'h001, s[3:1], s[0] & ~s[13]};
         ix = a[8:1];
         lat <= s[11:10];
         bus_idle <= s[12];
         if (s[13]) m[s[9]][ix] = s[31:16];
         else if (a[0]) m[s[9]][ix][7:0] = s[23:16];
         else m[s[9]][ix][15:8] = s[31:24];
         send(OP_MEM_BYTE_WR | {4'h0, s[13], s[9], 2'h0}, a, s[31:16], ea);
         e = s[14] ? m[s[9]][ix] : m[s[9]][ix] & (a[0] ? LANE_LOW : LANE_HIGH);
         rd(OP_MEM_BYTE_RD | {4'h0, s[14], s[9], 2'h0}, a, e, ea);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog
   initial
   begin
      #3_000_000;
      n_mismatch++;
      conclude();
   end
   // main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk(18'({cmd_ready, ack_enabled, mem_valid, bgnd_req}), 18'h0_0008, "reset");
      chk(18'(rd_data), 18'h0_0000, "reset data");
      chk(18'({reg_sel, cpu_freeze}), 18'({REG_PC, 1'b0}), "reset select");
      $display("test reset done");
      ea = 0;
      mem_loop(8);
      send(OP_ACK_ON, 16'h0000, 16'h0000, 1);
      chk(18'(ack_enabled), 18'h0_0001, "handshake on");
      ea = 1;
      mem_loop(12);
      $display("test memory done");
      for (int j = 0; j < 3; j++)
      begin
         lat <= (j == 1) ? 2'h3 : 2'h0;
         bus_idle <= (j != 2);
         frz = 0;
         rd(OP_MEM_WORD_RD, 16'h0010, m[0][8'h08], 1);
         gap = (t_mv - t_take) / 100;
         chk(18'(frz > 0), 18'(j > 0), "cpu freeze");
         chk(18'(j == 2 ? gap inside {[128:133]} : gap < 5), 18'h0_0001, "start");
      end
      $display("test cycle steal done");
      send(OP_ENTER_DEBUG, 16'h0000, 16'h0000, 0);
      chk(18'(cpu_in_debug | bgnd_req), 18'h0_0000, "enter disabled");
      send(8'h45, 16'h0000, 16'h1234, 0);
      send(8'h77, 16'h0000, 16'h0000, 0);
      debug_enable <= 1'b1;
      send(OP_ENTER_DEBUG, 16'h0000, 16'h0000, 1);
      chk({cpu_in_debug, dspace_visible}, 18'h0_0003, "in debug");
      chk(dspace_base, DSPACE_BASE, "window base");
      chk(dspace_last, DSPACE_LAST, "window last");
      rd(8'h65, 16'h0000, r[5], 1);
      for (k = 3; k < 8; k++)
      begin
         r[k] = 16'(rnd());
         send(8'h40 | 8'(k), 16'h0000, r[k], 1);
      end
      for (k = 3; k < 8; k++) rd(8'h60 | 8'(k), 16'h0000, r[k], 1);
      a = 16'h0014;
      d = 16'(rnd());
      send(8'h45, 16'h0000, a, 1);
      send(OP_WRITE_NEXT, 16'h0000, d, 1);
      m[1][a[8:1] + 8'h01] = d;
      rd(8'h65, 16'h0000, a + X_STEP, 1);
      send(8'h45, 16'h0000, a, 1);
      rd(OP_READ_NEXT, 16'h0000, d, 1);
      rd(OP_DSPACE_WORD_RD, a + X_STEP, d, 1);
      $display("test firmware done");
      for (int q = 0; q < 2; q++)
      begin
         k = n_res;
         send(q == 0 ? OP_RESUME : OP_TAG_RESUME, 16'h0000, 16'h0000, 1);
         chk({cpu_in_debug, 17'(n_res - k)}, 18'h0_0001, "resume");
         send(OP_ENTER_DEBUG, 16'h0000, 16'h0000, 1);
      end
      k = n_stp;
      send(OP_SINGLE_STEP, 16'h0000, 16'h0000, 1);
      chk({cpu_in_debug, 17'(n_stp - k)}, 18'h2_0001, "step");
      send(OP_RESUME_UNTIL, 16'h0000, 16'h0000, 0);
      k = n_ack;
      @(posedge ref_clk);
      brk <= 1'b1;
      @(posedge ref_clk);
      brk <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk({cpu_in_debug, 17'(n_ack - k)}, 18'h2_0001, "until ack");
      $display("test resume done");
      send(OP_ACK_OFF, 16'h0000, 16'h0000, 0);
      chk(18'(ack_enabled), 18'h0_0000, "handshake off");
      ea = 0;
      mem_loop(4);
      $display("test handshake off done");
      conclude();
   end
endmodule // debug_cmd_unit_tb
`default_nettype wire
